// ### sysmb_pkg.sv
/*
  Constants and types for the system configuration, mailbox and vector block.
  Assumes a 32-bit classic Wishbone register bus with registers in the low half.
*/
`default_nettype none
package sysmb_pkg;
  // ----------------------------------------
  // Register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [6:0] IDX_LOADER_CFG = 7'h02;
  localparam logic [6:0] IDX_MB_CTRL = 7'h06;
  localparam logic [6:0] IDX_MB_IN0 = 7'h08;
  localparam logic [6:0] IDX_MB_IN1 = 7'h0A;
  localparam logic [6:0] IDX_MB_OUT0 = 7'h0C;
  localparam logic [6:0] IDX_MB_OUT1 = 7'h0E;
  localparam logic [6:0] IDX_BERR_VEC = 7'h18;
  localparam logic [6:0] IDX_UNMI_VEC = 7'h1A;
  localparam logic [6:0] IDX_SNMI_VEC = 7'h1C;
  localparam logic [6:0] IDX_RST_VEC = 7'h1E;
  localparam logic [6:0] IDX_IRQ_STAT = 7'h20;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h21;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int POS_LOADER_PROT = 15;
  localparam int POS_LOADER_OFF = 14;
  localparam int POS_LOADER_RAM = 2;
  localparam int POS_MB_MODE = 4;
  localparam logic [1:0] RST_LOADER_SIZE = 2'h3;
  localparam logic [1:0] RST_OUT_READY = 2'h3;
  localparam logic [15:0] VACANT_WORD = 16'h3FFF;
  // Irq status bits: inbox, outbox, bus error, vacant access
  localparam int IRQ_W = 4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [3:0] BERR_WAIT_CYC = 4'h8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic sel;
    logic [15:0] wdat;
  } sysmb_dbg_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdat;
    logic [15:0] fl_rdat;
    logic loader_prot;
    logic loader_area_disable;
    logic loader_ram_assign;
    logic [1:0] loader_area_size;
    logic [1:0] autoclear_off;
    logic mailbox_width_select;
    logic [1:0] out_ready;
    logic [1:0] in_new;
    logic [15:0] in0;
    logic [15:0] in1;
    logic [15:0] out0;
    logic [15:0] out1;
    logic [15:0] dbg_rdat;
    logic [2:0] unmi;
    logic [8:0] snmi;
    logic [15:0] rstc;
    logic berr;
    logic [3:0] wcnt;
    logic in_ev;
    logic out_ev;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
  } sysmb_state_t;
endpackage : sysmb_pkg
`default_nettype wire

// ### sysmb_top.sv
/*
  System configuration registers: loader area control, debugger mailbox,
  four priority vector generators and a maskable interrupt.
  Assumes debugger and event inputs already sit in the sys_clk domain.
*/
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sysmb_top
  import sysmb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire sysmb_dbg_t dbg,
  output logic [15:0] dbg_rdata,
  output logic [1:0] dbg_in_new,
  output logic [1:0] dbg_out_ready,
  input wire logic fl_rd,
  input wire logic [2:0] fl_seg,
  input wire logic [15:0] fl_data,
  output logic [15:0] fl_rdata,
  output logic loader_area_disable,
  output logic loader_prot,
  output logic loader_ram_assign,
  output logic [1:0] loader_area_size,
  input wire logic [2:0] unmi_set,
  input wire logic [6:0] snmi_set,
  input wire logic pwr_on,
  input wire logic [15:0] rst_cause,
  input wire logic periph_wait,
  output logic periph_timeout
);
  sysmb_state_t q;
  sysmb_state_t n;
  logic req;
  logic wr;
  logic rd;
  logic [6:0] idx;
  logic [15:0] wv;
  logic in_area;
  logic vac;
  logic in_lvl;
  logic out_lvl;
  logic [15:0] uvec;
  logic [15:0] svec;
  logic [15:0] rvec;
  logic [15:0] bvec;
  logic [8:0] snmi_in;
  logic [IRQ_W-1:0] iev;

  // Code of lowest set bit, lowest index wins
  function automatic logic [15:0] prio(input logic [15:0] f);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 15; i >= 0; i--)
    begin
      if (f[i])
        v = 16'((i + 1) * 2);
    end
    return v;
  endfunction : prio

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
                                        input logic [1:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge

  // ----------------------------------------
  // Decode and vectors
  // ----------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign idx = wb_adr_i[8:2];
  assign wv = wb_dat_i[15:0];
  assign in_area = (fl_seg == 3'h3) || (fl_seg == 3'h2 && q.loader_area_size != 2'h0) ||
                   (fl_seg == 3'h1 && q.loader_area_size[1]) ||
                   (fl_seg == 3'h4 && q.loader_area_size == 2'h3);
  assign vac = in_area & q.loader_area_disable;
  // width selects one or both pairs
  assign in_lvl = q.mailbox_width_select ? &q.in_new : q.in_new[0];
  assign out_lvl = q.mailbox_width_select ? &q.out_ready : q.out_ready[0];
  assign uvec = prio({13'h0000, q.unmi});
  assign svec = prio({7'h00, q.snmi});
  assign rvec = prio(q.rstc);
  assign bvec = prio({15'h0000, q.berr});
  assign periph_timeout = periph_wait && q.wcnt == BERR_WAIT_CYC - 4'h1;
  // Level-reached pair sits above the vacant access event; snmi_set[6] has no slot
  assign snmi_in = {snmi_set[5:4], out_lvl & ~q.out_ev, in_lvl & ~q.in_ev,
                    vac & fl_rd, snmi_set[3:0]};
  // Mailbox bits land in order in, out on the vector
  assign iev = {vac & fl_rd, periph_timeout, out_lvl & ~q.out_ev, in_lvl & ~q.in_ev};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = q;
    n.ack = req;
    n.wcnt = periph_wait ? (q.wcnt == BERR_WAIT_CYC ? q.wcnt : q.wcnt + 4'h1) : 4'h0;
    n.in_ev = in_lvl;
    n.out_ev = out_lvl;
    n.fl_rdat = vac ? VACANT_WORD : fl_data;
    if (dbg.rd)
      n.dbg_rdat = dbg.sel ? q.out1 : q.out0;
    if (rd)
    begin
      case (idx)
        IDX_LOADER_CFG: n.rdat = {q.loader_prot, q.loader_area_disable, 11'h000,
                                  q.loader_ram_assign, q.loader_area_size};
        IDX_MB_CTRL: n.rdat = {8'h00, q.autoclear_off[1], q.autoclear_off[0], 1'b0,
                               q.mailbox_width_select, q.out_ready, q.in_new};
        IDX_MB_IN0: n.rdat = q.in0;
        IDX_MB_IN1: n.rdat = q.in1;
        IDX_MB_OUT0: n.rdat = q.out0;
        IDX_MB_OUT1: n.rdat = q.out1;
        IDX_BERR_VEC: n.rdat = bvec;
        IDX_UNMI_VEC: n.rdat = uvec;
        IDX_SNMI_VEC: n.rdat = svec;
        IDX_RST_VEC: n.rdat = rvec;
        IDX_IRQ_STAT: n.rdat = {12'h000, q.ist};
        IDX_IRQ_MASK: n.rdat = {12'h000, q.imask};
        default: n.rdat = 16'h0000;
      endcase
      if (idx == IDX_MB_IN0 && !q.autoclear_off[0])
        n.in_new[0] = 1'b0;
      if (idx == IDX_MB_IN1 && !q.autoclear_off[1])
        n.in_new[1] = 1'b0;
      // Reading a vector retires the reported source
      if (idx == IDX_UNMI_VEC)
        n.unmi = q.unmi & (q.unmi - 3'h1);
      if (idx == IDX_SNMI_VEC)
        n.snmi = q.snmi & (q.snmi - 9'h001);
      if (idx == IDX_RST_VEC)
        n.rstc = q.rstc & (q.rstc - 16'h0001);
      if (idx == IDX_BERR_VEC)
        n.berr = 1'b0;
    end
    if (wr)
    begin
      case (idx)
        IDX_LOADER_CFG:
        begin
          if (wb_sel_i[1])
          begin
            n.loader_prot = wv[POS_LOADER_PROT];
            n.loader_area_disable = wv[POS_LOADER_OFF];
          end
          if (wb_sel_i[0])
          begin
            n.loader_ram_assign = wv[POS_LOADER_RAM];
            n.loader_area_size = wv[1:0];
          end
        end
        IDX_MB_CTRL:
        begin
          if (wb_sel_i[0])
          begin
            n.autoclear_off = wv[7:6];
            n.mailbox_width_select = wv[POS_MB_MODE];
            n.in_new = wv[1:0];
          end
        end
        IDX_MB_OUT0:
        begin
          n.out0 = merge(q.out0, wv, wb_sel_i[1:0]);
          // upper or word write clears ready
          if (wb_sel_i[1])
            n.out_ready[0] = 1'b0;
        end
        IDX_MB_OUT1:
        begin
          n.out1 = merge(q.out1, wv, wb_sel_i[1:0]);
          if (wb_sel_i[1])
            n.out_ready[1] = 1'b0;
        end
        IDX_BERR_VEC: n.berr = 1'b0;
        IDX_UNMI_VEC: n.unmi = 3'h0;
        IDX_SNMI_VEC: n.snmi = 9'h000;
        IDX_RST_VEC: n.rstc = 16'h0000;
        IDX_IRQ_STAT:
        begin
          if (wb_sel_i[0])
            n.ist = q.ist & ~wv[IRQ_W-1:0];
        end
        IDX_IRQ_MASK:
        begin
          if (wb_sel_i[0])
            n.imask = wv[IRQ_W-1:0];
        end
        default: n.rdat = q.rdat;
      endcase
    end
    // Hardware sets come last so they win over clears
    // inbox loaded only by the debugger
    if (dbg.wr && !dbg.sel)
    begin
      n.in0 = dbg.wdat;
      n.in_new[0] = 1'b1;
    end
    // second inbox unused in narrow mode
    if (dbg.wr && dbg.sel && q.mailbox_width_select)
    begin
      n.in1 = dbg.wdat;
      n.in_new[1] = 1'b1;
    end
    if (dbg.rd)
      n.out_ready[dbg.sel] = 1'b1;
    n.unmi = n.unmi | unmi_set;
    n.snmi = n.snmi | snmi_in;
    n.berr = n.berr | periph_timeout;
    n.ist = n.ist | iev;
    n.rstc = (pwr_on ? 16'h0000 : n.rstc) | rst_cause;
    if (srst)
    begin
      n = '0;
      n.rstc = (pwr_on ? 16'h0000 : q.rstc) | rst_cause;
      n.loader_prot = 1'b1;
      n.loader_area_size = RST_LOADER_SIZE;
      n.out_ready = RST_OUT_READY;
      // Tracker starts at the idle ready level, so no event follows reset
      n.out_ev = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    q <= n;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_o = q.ack;
  assign wb_dat_o = {16'h0000, q.rdat};
  assign irq = |(q.ist & q.imask);
  assign dbg_rdata = q.dbg_rdat;
  assign dbg_in_new = q.in_new;
  assign dbg_out_ready = q.out_ready;
  assign fl_rdata = q.fl_rdat;
  assign loader_area_disable = q.loader_area_disable;
  assign loader_prot = q.loader_prot;
  assign loader_ram_assign = q.loader_ram_assign;
  assign loader_area_size = q.loader_area_size;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  vacant_read_a: assert property (fl_rd && vac |=> fl_rdata == VACANT_WORD)
    else $error("vacant loader read returned data");
  seg4_small_a: assert property (fl_rd && fl_seg == 3'h4 && q.loader_area_size != 2'h3
    |=> fl_rdata == $past(fl_data))
    else $error("segment 4 hidden outside full size");
  narrow_in1_a: assert property (!q.mailbox_width_select && dbg.wr && dbg.sel
    |=> $stable(q.in1))
    else $error("inbox 1 loaded in narrow mode");
  inbox_ro_a: assert property (wr && idx == IDX_MB_IN0 && !dbg.wr |=> $stable(q.in0))
    else $error("software changed inbox 0");
  outbox_wr_a: assert property (wr && idx == IDX_MB_OUT0 && wb_sel_i[1:0] == 2'h3
    |=> q.out0 == $past(wv))
    else $error("outbox 0 not stored");
  sequence in_read_s;
    rd && idx == IDX_MB_IN0 && !q.autoclear_off[0] && !dbg.wr;
  endsequence
  inbox_clear_a: assert property (in_read_s ##1 wb_ack_o |-> !q.in_new[0])
    else $error("inbox flag kept after read");
  out_clear_a: assert property (wr && idx == IDX_MB_OUT0 && wb_sel_i[1] && !dbg.rd
    |=> !q.out_ready[0])
    else $error("outbox ready not cleared");
  unmi_prio_a: assert property (q.unmi[0] |-> uvec == 16'h0002 && !uvec[0])
    else $error("pin flag not top priority");
  unmi_wclr_a: assert property (wr && idx == IDX_UNMI_VEC && unmi_set == 3'h0
    |=> q.unmi == 3'h0)
    else $error("user flags survive write");
  snmi_wclr_a: assert property (wr && idx == IDX_SNMI_VEC && snmi_in == 9'h000
    |=> q.snmi == 9'h000 && svec == 16'h0000)
    else $error("system flags survive write");
  rst_wclr_a: assert property (wr && idx == IDX_RST_VEC && rst_cause == 16'h0000 && !pwr_on
    |=> rvec == 16'h0000)
    else $error("reset causes survive write");
  sequence wait8_s;
    !periph_wait ##1 periph_wait [* 8];
  endsequence
  berr_time_a: assert property (wait8_s |-> periph_timeout ##1 bvec == 16'h0002)
    else $error("bus error not raised at 8 cycles");
  berr_wclr_a: assert property (wr && idx == IDX_BERR_VEC && !periph_timeout
    |=> bvec == 16'h0000)
    else $error("bus error survives write");

  // ----------------------------------------
  // Loader pass-through, vector codes and debugger side
  // ----------------------------------------
  loader_pass_a: assert property (fl_rd && !vac |=> fl_rdata == $past(fl_data))
    else $error("loader area word not passed through");
  vec_idle_a: assert property (q.unmi == 3'h0 && q.rstc == 16'h0000 && !q.berr
    |-> (uvec | rvec | bvec) == 16'h0000)
    else $error("idle vector not zero");
  unmi_codes_a: assert property (!q.unmi[0] && q.unmi[2:1] != 2'h0
    |-> uvec == (q.unmi[1] ? 16'h0004 : 16'h0006))
    else $error("user code out of order");
  snmi_vacant_a: assert property (q.snmi[4] && q.snmi[3:0] == 4'h0
    |-> svec == 16'h000A)
    else $error("vacant access code wrong");
  snmi_inbox_a: assert property (q.snmi[5] && q.snmi[4:0] == 5'h00
    |-> svec == 16'h000C)
    else $error("mailbox input code wrong");
  snmi_outbox_a: assert property (q.snmi[6] && q.snmi[5:0] == 6'h00
    |-> svec == 16'h000E)
    else $error("mailbox output code wrong");
  snmi_last_a: assert property (q.snmi == 9'h100 |-> svec == 16'h0012)
    else $error("last system code wrong");
  rst_first_a: assert property (q.rstc[0] |-> rvec == 16'h0002)
    else $error("brown-out code not first");
  rst_last_a: assert property (q.rstc == 16'h8000 |-> rvec == 16'h0020)
    else $error("last reset code wrong");
  sequence in1_load_s;
    q.mailbox_width_select && dbg.wr && dbg.sel;
  endsequence
  wide_in1_a: assert property (in1_load_s
    |=> q.in1 == $past(dbg.wdat) && q.in_new[1])
    else $error("inbox 1 not loaded in wide mode");
  inbox_load_a: assert property (dbg.wr && !dbg.sel
    |=> q.in_new[0] && q.in0 == $past(dbg.wdat))
    else $error("inbox 0 load or flag missing");
  outbox_read_a: assert property (dbg.rd && !dbg.sel
    |=> dbg_out_ready[0] && dbg_rdata == $past(q.out0))
    else $error("outbox 0 read not re-armed");
  wide_out1_a: assert property (q.mailbox_width_select && dbg.rd && dbg.sel
    |=> dbg_out_ready[1] && dbg_rdata == $past(q.out1))
    else $error("outbox 1 not read in wide mode");
  berr_idle_a: assert property (!periph_wait |-> !periph_timeout)
    else $error("timeout without wait state");
endmodule : sysmb_top
`default_nettype wire

// ### sysmb_dbg_model.sv
/*
  Debugger-side model of the mailbox port: one-cycle write and read strobes.
  Assumes callers enter its tasks just after a rising sys_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sysmb_dbg_model
  import sysmb_pkg::*;
(
  input wire logic sys_clk,
  output var sysmb_dbg_t dbg
);
  initial dbg = '0;

  // Released data is inverted so a stale word never looks valid
  task put(input logic s, input logic [15:0] d);
    dbg.wr <= 1'b1;
    dbg.sel <= s;
    dbg.wdat <= d;
    @(posedge sys_clk);
    dbg.wr <= 1'b0;
    dbg.wdat <= ~d;
  endtask : put

  task get(input logic s);
    dbg.rd <= 1'b1;
    dbg.sel <= s;
    @(posedge sys_clk);
    dbg.rd <= 1'b0;
  endtask : get
endmodule : sysmb_dbg_model
`default_nettype wire

// ### testbench.sv
/*
  Self-checking bench: Wishbone master tasks, debugger model and an integer
  reference of the flag vectors and outbox queue.
  Assumes sysmb_pkg and sysmb_dbg_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sysmb_pkg::*;
;
  logic sys_clk, srst, cyc, stb, we, ack, irq, fl_rd, pwr_on, periph_wait, periph_timeout;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  logic [2:0] fl_seg, unmi_set;
  logic [6:0] snmi_set;
  logic [15:0] fl_data, fl_rdata, rst_cause, dbg_rdata, rd, r;
  logic [1:0] in_new, out_ready;
  logic [4:0] cfg;
  logic [15:0] oq [$];
  sysmb_dbg_t dbg;
  int n_mismatch = 0, comparisons = 0, cycles = 0, seed = 32'hE6FC, pu, ps, pr;
  logic [6:0] ri [13] = '{IDX_LOADER_CFG, IDX_MB_CTRL, IDX_MB_IN0, IDX_MB_IN1, IDX_MB_OUT0,
    IDX_MB_OUT1, IDX_UNMI_VEC, IDX_SNMI_VEC, IDX_BERR_VEC, IDX_IRQ_MASK, 7'h05,
    IDX_RST_VEC, IDX_RST_VEC};
  logic [15:0] rv [13] = '{16'h8003, 16'h000C, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0000};

  sysmb_top i_dut (
    .sys_clk(sys_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq(irq), .dbg(dbg), .dbg_rdata(dbg_rdata), .dbg_in_new(in_new),
    .dbg_out_ready(out_ready), .fl_rd(fl_rd), .fl_seg(fl_seg), .fl_data(fl_data),
    .fl_rdata(fl_rdata), .loader_area_disable(cfg[4]), .loader_prot(cfg[3]),
    .loader_ram_assign(cfg[2]), .loader_area_size(cfg[1:0]), .unmi_set(unmi_set),
    .snmi_set(snmi_set), .pwr_on(pwr_on),
    .rst_cause(rst_cause), .periph_wait(periph_wait), .periph_timeout(periph_timeout)
  );
  sysmb_dbg_model i_dbg (.sys_clk(sys_clk), .dbg(dbg));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  // Request held until ack is sampled, then one idle cycle
  task wb(input logic w, input logic [6:0] idx, input logic [15:0] d, input logic [1:0] s);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {23'h0, idx, 2'h0};
    sel <= {2'h0, s};
    wdat <= {16'h0, d};
    @(posedge sys_clk);
    while (ack !== 1'b1)
      @(posedge sys_clk);
    rd = rdat[15:0];
    {cyc, stb} <= 2'b00;
    @(posedge sys_clk);
  endtask : wb

  task rdc(input logic [6:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000, 2'h3);
    check(rd, exp);
  endtask : rdc

  function automatic logic [15:0] code(int p);
    for (int i = 0; i < 16; i++)
      if (p[i])
        return 16'(2 * i + 2);
    return 16'h0000;
  endfunction : code

  // Each read reports the lowest pending code and retires it
  task drain(input logic [6:0] idx, inout int p, input int n);
    repeat (n)
    begin
      rdc(idx, code(p));
      p = p & (p - 1);
    end
  endtask : drain

  task pulse(input logic [2:0] u, input logic [6:0] s, input logic [15:0] c);
    {unmi_set, snmi_set, rst_cause} <= {u, s, c};
    @(posedge sys_clk);
    {unmi_set, snmi_set, rst_cause} <= '0;
    @(posedge sys_clk);
  endtask : pulse

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {cyc, stb, we, adr, sel, wdat, fl_rd, fl_seg, fl_data, unmi_set, snmi_set, periph_wait} = '0;
    {srst, pwr_on, rst_cause} = {2'b11, 16'h0001};
    repeat (3) @(posedge sys_clk);
    {srst, pwr_on, rst_cause} <= '0;
    @(posedge sys_clk);
    foreach (ri[i])
      rdc(ri[i], rv[i]);
    $display("reset test done");
    for (int k = 0; k < 8; k++)
    begin
      wb(1'b1, IDX_LOADER_CFG, {1'b1, k[2], 12'h000, k[1:0]}, 2'h3);
      for (int g = 1; g < 5; g++)
      begin
        r = 16'($random(seed));
        {fl_rd, fl_seg, fl_data} <= {1'b1, 3'(g), r};
        @(posedge sys_clk);
        {fl_rd, fl_data} <= {1'b0, ~r};
        @(posedge sys_clk);
        check(fl_rdata, (k[2] && (g == 4 ? k[1:0] == 2'h3 : g >= 3 - k[1:0])) ? VACANT_WORD : r);
      end
    end
    rdc(IDX_LOADER_CFG, 16'hC003);
    check({11'h000, cfg}, 16'h001B);
    wb(1'b1, IDX_LOADER_CFG, 16'h8007, 2'h3);
    rdc(IDX_LOADER_CFG, 16'h8007);
    check({11'h000, cfg}, 16'h000F);
    rdc(IDX_SNMI_VEC, 16'h000A);
    rdc(IDX_SNMI_VEC, 16'h0000);
    $display("loader test done");
    pulse(3'h7, 7'h00, 16'h0000);
    pu = 7;
    drain(IDX_UNMI_VEC, pu, 4);
    pulse(3'h5, 7'h00, 16'h0000);
    wb(1'b1, IDX_UNMI_VEC, 16'h0000, 2'h3);
    rdc(IDX_UNMI_VEC, 16'h0000);
    pulse(3'h0, 7'h3F, 16'h0000);
    ps = 32'h18F;
    drain(IDX_SNMI_VEC, ps, 5);
    wb(1'b1, IDX_SNMI_VEC, 16'h0000, 2'h3);
    rdc(IDX_SNMI_VEC, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      pulse(3'h0, 7'h00, 16'(1 << i));
      rdc(IDX_RST_VEC, 16'(2 * i + 2));
    end
    r = 16'($random(seed));
    pr = r;
    pulse(3'h0, 7'h00, r);
    drain(IDX_RST_VEC, pr, 3);
    wb(1'b1, IDX_RST_VEC, 16'h0000, 2'h3);
    rdc(IDX_RST_VEC, 16'h0000);
    $display("vector test done");
    periph_wait <= 1'b1;
    for (int i = 1; i < 9; i++)
    begin
      @(posedge sys_clk);
      check({15'h0, periph_timeout}, {15'h0, i == 8});
    end
    periph_wait <= 1'b0;
    @(posedge sys_clk);
    rdc(IDX_BERR_VEC, 16'h0002);
    wb(1'b1, IDX_BERR_VEC, 16'h0000, 2'h3);
    rdc(IDX_BERR_VEC, 16'h0000);
    $display("bus error test done");
    r = 16'($random(seed));
    i_dbg.put(1'b0, r);
    rdc(IDX_MB_CTRL, 16'h000D);
    rdc(IDX_MB_IN0, r);
    rdc(IDX_MB_CTRL, 16'h000C);
    rdc(IDX_SNMI_VEC, 16'h000C);
    wb(1'b1, IDX_MB_IN0, ~r, 2'h3);
    rdc(IDX_MB_IN0, r);
    check({15'h0, irq}, 16'h0000);
    wb(1'b1, IDX_IRQ_MASK, 16'h0001, 2'h3);
    check({15'h0, irq}, 16'h0001);
    rdc(IDX_IRQ_STAT, 16'h000D);
    wb(1'b1, IDX_IRQ_STAT, 16'h000F, 2'h3);
    check({15'h0, irq}, 16'h0000);
    wb(1'b1, IDX_MB_OUT0, 16'h00A5, 2'h1);
    rdc(IDX_MB_CTRL, 16'h000C);
    wb(1'b1, IDX_MB_OUT0, r, 2'h2);
    oq.push_back({r[15:8], 8'hA5});
    rdc(IDX_MB_CTRL, 16'h0008);
    rdc(IDX_MB_OUT0, oq[0]);
    i_dbg.get(1'b0);
    @(posedge sys_clk);
    check(dbg_rdata, oq.pop_front());
    check({14'h0, out_ready}, 16'h0003);
    rdc(IDX_SNMI_VEC, 16'h000E);
    i_dbg.put(1'b1, r);
    rdc(IDX_MB_IN1, 16'h0000);
    // width changed only with the mailbox drained
    wb(1'b1, IDX_MB_CTRL, 16'h00D0, 2'h3);
    i_dbg.put(1'b1, ~r);
    @(posedge sys_clk);
    i_dbg.put(1'b0, r);
    rdc(IDX_MB_IN1, ~r);
    rdc(IDX_MB_IN0, r);
    rdc(IDX_MB_CTRL, 16'h00DF);
    wb(1'b1, IDX_MB_CTRL, 16'h00D0, 2'h3);
    rdc(IDX_MB_CTRL, 16'h00DC);
    wb(1'b1, IDX_MB_OUT0, r, 2'h3);
    oq.push_back(r);
    wb(1'b1, IDX_MB_OUT1, ~r, 2'h3);
    oq.push_back(~r);
    rdc(IDX_MB_CTRL, 16'h00D0);
    rdc(IDX_MB_OUT1, oq[1]);
    i_dbg.get(1'b0);
    @(posedge sys_clk);
    check(dbg_rdata, oq.pop_front());
    rdc(IDX_SNMI_VEC, 16'h000C);
    i_dbg.get(1'b1);
    @(posedge sys_clk);
    check(dbg_rdata, oq.pop_front());
    rdc(IDX_MB_CTRL, 16'h00DC);
    rdc(IDX_SNMI_VEC, 16'h000E);
    $display("mailbox test done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
